/* dv/dfs_master_model.sv */
// Fieldbus master model: writes both command words and keeps the watchdog pulse
`timescale 1ns/10ps
module dfs_master_model
	import dfs_pkg::*;
(
	input  wire logic clk_i,
	output dfs_word_t ctrl_word_o,
	output logic      ctrl_wr_o,
	output dfs_word_t simple_word_o,
	output logic      simple_wr_o
);
	logic wd = 1'b0;
	initial begin
		ctrl_word_o = CTRL_RST;
		ctrl_wr_o = 1'b0;
		simple_word_o = SIMPLE_RST;
		simple_wr_o = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Word is scrambled once the strobe drops so a stale value is never trusted
	task automatic wctl(input dfs_word_t w);
		@(posedge clk_i);
		ctrl_word_o <= {w[15:12], wd, w[10:0]};
		ctrl_wr_o <= 1'b1;
		@(posedge clk_i);
		ctrl_wr_o <= 1'b0;
		ctrl_word_o <= ~ctrl_word_o;
	endtask
	// Caller flips the pulse in place of a one second timer, keeping runs short
	task automatic tog();
		wd = ~wd;
	endtask
	task automatic wsim(input dfs_word_t w);
		@(posedge clk_i);
		simple_word_o <= w;
		simple_wr_o <= 1'b1;
		@(posedge clk_i);
		simple_wr_o <= 1'b0;
		simple_word_o <= ~simple_word_o;
	endtask
endmodule // dfs_master_model

/* dv/tb_top.sv */
// Self-checking bench for the fieldbus status word block
`timescale 1ns/10ps
module tb_top
	import dfs_pkg::*;
;
	typedef struct packed {
		logic [11:0] lv;
		dfs_word_t   a, t, tol, thr;
		logic [10:0] ex;
	} dfs_row_s;
	localparam dfs_row_s ROWS [6] = '{
		'{12'hff8, 16'h0064, 16'h0067, 16'h0003, 16'h0064, 11'h107},
		'{12'hff0, 16'h0068, 16'h0064, 16'h0003, 16'h0067, 11'h403},
		'{12'h7e7, 16'h0000, 16'h0000, 16'h0000, 16'hffff, 11'h38e},
		'{12'h000, 16'hffff, 16'h0000, 16'hfffe, 16'hfffe, 11'h400},
		'{12'he7c, 16'h0005, 16'h000a, 16'h0005, 16'h0004, 11'h50c},
		'{12'h000, 16'h0000, 16'h0010, 16'h0000, 16'hffff, 11'h000}};
	localparam dfs_word_t CW [5] = '{16'h0007, 16'h0006, 16'h0007, 16'h0005, 16'h7003};
	localparam dfs_word_t CE [5] = '{16'h0070, 16'h8070, 16'h8030, 16'h0060, 16'h0050};
	localparam dfs_word_t SW [7] = '{16'hfff8, 16'h0001, 16'h0002, 16'h0005, 16'h0005,
		16'h0003, 16'h0006};
	localparam logic [2:0] SE [7] = '{3'h0, 3'h4, 3'h2, 3'h5, 3'h4, 3'h6, 3'h3};
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [11:0] lv = 12'h000;
	dfs_word_t   a = 16'h0000, t = 16'h0000, tol = 16'h0000, thr = 16'h0000;
	dfs_word_t   cw, sw, st;
	logic        cwr, swr, run, ccw, frs;
	int          error_cnt = 0;
	int          compares = 0;
	always #4 clk = ~clk;
	dfs_master_model m (.clk_i(clk), .ctrl_word_o(cw), .ctrl_wr_o(cwr),
		.simple_word_o(sw), .simple_wr_o(swr));
	dfs_status_top dut (.clk_i(clk), .rst_n_i(rst_n), .ctrl_word_i(cw), .ctrl_wr_i(cwr),
		.simple_command_word_i(sw), .simple_command_wr_i(swr),
		.supply_on_i(lv[11]), .electronics_init_i(lv[10]), .contactor_open_i(lv[9]),
		.pulses_inhibited_i(lv[8]), .ready_run_i(lv[7]), .modulating_i(lv[6]),
		.flux_ready_i(lv[5]), .brake_fb_used_i(lv[4]), .brake_open_i(lv[3]),
		.fault_active_i(lv[2]), .warning_i(lv[1]), .remote_control_granted_i(lv[0]),
		.speed_actual_i(a), .speed_target_i(t), .speed_tolerance_i(tol),
		.speed_threshold_setting_i(thr), .drive_state_report_word_o(st),
		.run_cmd_o(run), .ccw_o(ccw), .fault_reset_o(frs));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk_w(input dfs_word_t g, input dfs_word_t e);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic test_done();
		if (error_cnt == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Two edges cover capture plus the registered status stage
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		foreach (ROWS[i]) begin
			@(posedge clk);
			{lv, a, t, tol, thr} <= {ROWS[i].lv, ROWS[i].a, ROWS[i].t, ROWS[i].tol, ROWS[i].thr};
			settle();
			chk_w(st, {5'h00, ROWS[i].ex | 11'h040});
			chk_w(st, {5'h00, ROWS[i].ex | 11'h040});
		end
		// Stops lifted with ON already high must not release the inhibit; OFF then ON does, and a coast stop sets it again
		foreach (CW[i]) begin
			if (i % 2 == 1) m.tog();
			m.wctl(CW[i]);
			settle();
			chk_w(st & 16'hf870, CE[i]);
		end
		foreach (SW[i]) begin
			m.wsim(SW[i]);
			#1;
			chk_w({13'h0000, run, ccw, frs}, {13'h0000, SE[i]});
			@(posedge clk);
			#1;
			chk_w({15'h0000, frs}, 16'h0000);
		end
		@(posedge clk);
		rst_n <= 1'b0;
		#1;
		chk_w(st, STATUS_RST);
		chk_w({13'h0000, run, ccw, frs}, 16'h0000);
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		settle();
		chk_w(st, STATUS_RST);
		test_done();
	end
	// Whole sequence needs well under a thousand cycles
	initial begin
		#20000;
		error_cnt++;
		test_done();
	end
endmodule // tb_top

/* logic/dfs_pkg.sv */
// Constants and types shared by the fieldbus status/control word block
package dfs_pkg;

	localparam int WORD_W = 16;

	// Status word bit positions
	localparam int ST_RDY_ON   = 0;
	localparam int ST_RDY_RUN  = 1;
	localparam int ST_RUNNING  = 2;
	localparam int ST_FAULT    = 3;
	localparam int ST_NO_COAST = 4;
	localparam int ST_NO_QUICK = 5;
	localparam int ST_INHIBIT  = 6;
	localparam int ST_WARN     = 7;
	localparam int ST_AT_REF   = 8;
	localparam int ST_REMOTE   = 9;
	localparam int ST_ABOVE    = 10;
	localparam int ST_SPARE_LO = 11;
	localparam int ST_SPARE_HI = 14;
	localparam int ST_WDOG     = 15;

	// Full control word bit positions
	localparam int CW_ON    = 0;
	localparam int CW_COAST = 1;
	localparam int CW_QUICK = 2;
	localparam int CW_WDOG  = 11;

	// Simplified command word bit positions
	localparam int SC_START = 0;
	localparam int SC_DIR   = 1;
	localparam int SC_RESET = 2;

	// Reset values: drive starts inhibited, coast and quick stop asserted
	localparam logic [WORD_W-1:0] STATUS_RST = 16'h0040;
	localparam logic [WORD_W-1:0] CTRL_RST   = 16'h0000;
	localparam logic [WORD_W-1:0] SIMPLE_RST = 16'h0000;
	localparam logic [3:0]        SPARE_ZERO = 4'h0;

	typedef logic [WORD_W-1:0] dfs_word_t;

	typedef struct packed {
		dfs_word_t ctrl;
		dfs_word_t simple;
		logic      inhibit;
		logic      armed;
		logic      freset;
		dfs_word_t stat;
	} dfs_top_s;

	function automatic dfs_word_t dfs_abs_diff(input dfs_word_t a, input dfs_word_t b);
		dfs_abs_diff = (a >= b) ? dfs_word_t'(a - b) : dfs_word_t'(b - a);
	endfunction

endpackage

/* logic/dfs_speed_cmp.sv */
// Combinational speed-at-reference and above-limit comparator
`timescale 1ns/10ps
module dfs_speed_cmp
	import dfs_pkg::*;
(
	dfs_speed_if.cmp spd
);

	always_comb begin
		// Inclusive tolerance band so a zero tolerance still matches exact equality
		spd.at_ref = (dfs_abs_diff(spd.actual, spd.target) <= spd.tolerance);
		// Equal to the limit counts as not above
		spd.above  = (spd.actual > spd.limit);
	end

endmodule // dfs_speed_cmp

/* logic/dfs_speed_if.sv */
// Speed comparison signals between the status block and its comparator
`timescale 1ns/10ps
interface dfs_speed_if;
	import dfs_pkg::*;
	dfs_word_t actual;
	dfs_word_t target;
	dfs_word_t tolerance;
	dfs_word_t limit;
	logic      at_ref;
	logic      above;

	modport cmp  (input actual, input target, input tolerance, input limit,
	              output at_ref, output above);
	modport user (output actual, output target, output tolerance, output limit,
	              input at_ref, input above);
endinterface

/* logic/dfs_status_top.sv */
// Fieldbus status word generator and simplified control word decoder
`timescale 1ns/10ps
module dfs_status_top
	import dfs_pkg::*;
(
	input  wire logic      clk_i,
	input  wire logic      rst_n_i,
	// Full control word from the fieldbus master
	input  wire dfs_word_t ctrl_word_i,
	input  wire logic      ctrl_wr_i,
	// Simplified command word from the fieldbus master
	input  wire dfs_word_t simple_command_word_i,
	input  wire logic      simple_command_wr_i,
	// Drive condition inputs
	input  wire logic      supply_on_i,
	input  wire logic      electronics_init_i,
	input  wire logic      contactor_open_i,
	input  wire logic      pulses_inhibited_i,
	input  wire logic      ready_run_i,
	input  wire logic      modulating_i,
	input  wire logic      flux_ready_i,
	input  wire logic      brake_fb_used_i,
	input  wire logic      brake_open_i,
	input  wire logic      fault_active_i,
	input  wire logic      warning_i,
	input  wire logic      remote_control_granted_i,
	input  wire dfs_word_t speed_actual_i,
	input  wire dfs_word_t speed_target_i,
	input  wire dfs_word_t speed_tolerance_i,
	input  wire dfs_word_t speed_threshold_setting_i,
	// Outputs
	output dfs_word_t      drive_state_report_word_o,
	output logic           run_cmd_o,
	output logic           ccw_o,
	output logic           fault_reset_o
);

	dfs_speed_if spd ();
	dfs_top_s    s_q;
	dfs_top_s    s_d;
	logic        coast_clr;
	logic        quick_clr;

	assign spd.actual    = speed_actual_i;
	assign spd.target    = speed_target_i;
	assign spd.tolerance = speed_tolerance_i;
	assign spd.limit     = speed_threshold_setting_i;

	dfs_speed_cmp u_cmp (
		.spd (spd.cmp)
	);

	////////////////////////////////////////////////////////////////////////////

	// Coast and quick stop control word bits are active-low stop requests
	assign coast_clr = s_q.ctrl[CW_COAST];
	assign quick_clr = s_q.ctrl[CW_QUICK];

	always_comb begin
		s_d        = s_q;
		s_d.freset = 1'b0;
		if (ctrl_wr_i) begin
			s_d.ctrl = ctrl_word_i;
		end
		if (simple_command_wr_i) begin
			// Only b0..b2 matter; upper bits are stored but steer nothing
			s_d.simple = simple_command_word_i;
			// A rewrite of a steady 1 must not retrigger the reset
			s_d.freset = simple_command_word_i[SC_RESET] & ~s_q.simple[SC_RESET];
		end

		// Entry into inhibit wins over any release in the same cycle
		if (fault_active_i || !coast_clr || !quick_clr) begin
			s_d.inhibit = 1'b1;
			s_d.armed   = 1'b0;
		end else if (s_q.inhibit) begin
			if (!s_q.ctrl[CW_ON]) begin
				s_d.armed = 1'b1;
			end else if (s_q.armed) begin
				s_d.inhibit = 1'b0;
				s_d.armed   = 1'b0;
			end
		end

		s_d.stat              = '0;
		s_d.stat[ST_RDY_ON]   = supply_on_i & electronics_init_i
		                        & contactor_open_i & pulses_inhibited_i;
		s_d.stat[ST_RDY_RUN]  = ready_run_i;
		s_d.stat[ST_RUNNING]  = modulating_i & flux_ready_i
		                        & (~brake_fb_used_i | brake_open_i);
		s_d.stat[ST_FAULT]    = fault_active_i;
		s_d.stat[ST_NO_COAST] = coast_clr;
		s_d.stat[ST_NO_QUICK] = quick_clr;
		s_d.stat[ST_INHIBIT]  = s_d.inhibit;
		s_d.stat[ST_WARN]     = warning_i;
		s_d.stat[ST_AT_REF]   = spd.at_ref;
		s_d.stat[ST_REMOTE]   = remote_control_granted_i;
		s_d.stat[ST_ABOVE]    = spd.above;
		// Echo only; missing-pulse supervision lives in the drive's fault logic
		s_d.stat[ST_WDOG]     = s_q.ctrl[CW_WDOG];
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q.ctrl    <= CTRL_RST;
			s_q.simple  <= SIMPLE_RST;
			s_q.inhibit <= 1'b1;
			s_q.armed   <= 1'b0;
			s_q.freset  <= 1'b0;
			s_q.stat    <= STATUS_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign drive_state_report_word_o = s_q.stat;
	assign run_cmd_o                 = s_q.simple[SC_START];
	assign ccw_o                     = s_q.simple[SC_DIR];
	assign fault_reset_o             = s_q.freset;

	////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_READY_ON: assert property (
		(supply_on_i && electronics_init_i && contactor_open_i && !pulses_inhibited_i)
		|=> !drive_state_report_word_o[ST_RDY_ON]
	) else $error("ready-to-switch-on set with pulses enabled");

	AST_READY_SET: assert property (
		(supply_on_i && electronics_init_i && contactor_open_i && pulses_inhibited_i)
		|=> drive_state_report_word_o[ST_RDY_ON]
	) else $error("ready-to-switch-on clear with all conditions met");

	AST_RDY_RUN: assert property (
		$past(rst_n_i) |-> drive_state_report_word_o[ST_RDY_RUN] == $past(ready_run_i)
	) else $error("ready-to-run bit does not track ready condition");

	AST_RUN_FLUX: assert property (
		$past(rst_n_i) |-> drive_state_report_word_o[ST_RUNNING] == ($past(modulating_i)
			&& $past(flux_ready_i) && (!$past(brake_fb_used_i) || $past(brake_open_i)))
	) else $error("running bit does not follow modulation, flux and brake");

	AST_FAULT: assert property (
		fault_active_i |=> drive_state_report_word_o[ST_FAULT]
		                   && drive_state_report_word_o[ST_INHIBIT]
	) else $error("fault not reported");

	AST_FAULT_CLR: assert property (
		!fault_active_i |=> !drive_state_report_word_o[ST_FAULT]
	) else $error("fault bit set with no fault active");

	AST_COAST: assert property (
		(ctrl_wr_i && !ctrl_word_i[CW_COAST]) |=> ##1 !drive_state_report_word_o[ST_NO_COAST]
	) else $error("coast stop not reported two cycles after write");

	AST_QUICK: assert property (
		(ctrl_wr_i && !ctrl_word_i[CW_QUICK]) |=> ##1 !drive_state_report_word_o[ST_NO_QUICK]
	) else $error("quick stop not reported two cycles after write");

	AST_INHIBIT_REL: assert property (
		$fell(s_q.inhibit) |-> $past(s_q.armed) && $past(s_q.ctrl[CW_ON])
		                       && $past(coast_clr) && $past(quick_clr) && !$past(fault_active_i)
	) else $error("inhibit released without stops removed and OFF then ON");

	AST_INHIBIT_SET: assert property (
		(!coast_clr || !quick_clr) |=> drive_state_report_word_o[ST_INHIBIT]
	) else $error("inhibit clear while a stop command is stored");

	AST_WARN: assert property (
		$past(rst_n_i) |-> drive_state_report_word_o[ST_WARN] == $past(warning_i)
	) else $error("warning bit does not track warning");

	AST_AT_REF: assert property (
		(dfs_abs_diff(speed_actual_i, speed_target_i) > speed_tolerance_i)
		|=> !drive_state_report_word_o[ST_AT_REF]
	) else $error("speed at reference set outside tolerance");

	AST_AT_REF_SET: assert property (
		(dfs_abs_diff(speed_actual_i, speed_target_i) <= speed_tolerance_i)
		|=> drive_state_report_word_o[ST_AT_REF]
	) else $error("speed at reference clear inside tolerance");

	AST_REMOTE: assert property (
		$past(rst_n_i) |-> drive_state_report_word_o[ST_REMOTE] == $past(remote_control_granted_i)
	) else $error("control request bit does not track control grant");

	AST_ABOVE: assert property (
		drive_state_report_word_o[ST_ABOVE]
		|-> $past(speed_actual_i) > $past(speed_threshold_setting_i)
	) else $error("above limit set while speed not above limit");

	AST_ABOVE_CLR: assert property (
		(speed_actual_i <= speed_threshold_setting_i) |=> !drive_state_report_word_o[ST_ABOVE]
	) else $error("above limit set while speed at or below limit");

	AST_WDOG: assert property (
		ctrl_wr_i |=> ##1 drive_state_report_word_o[ST_WDOG] == $past(ctrl_word_i[CW_WDOG], 2)
	) else $error("watchdog echo wrong two cycles after write");

	AST_DIR: assert property (
		simple_command_wr_i |=> (ccw_o == $past(simple_command_word_i[SC_DIR]))
		                        && (run_cmd_o == $past(simple_command_word_i[SC_START]))
	) else $error("start or direction not taken from command word");

	AST_FRESET: assert property (
		fault_reset_o |-> $past(simple_command_wr_i) && $past(simple_command_word_i[SC_RESET])
		                  && !$past(s_q.simple[SC_RESET]) ##1 !fault_reset_o
	) else $error("fault reset without rising edge or longer than one cycle");

	AST_SPARE: assert property (
		drive_state_report_word_o[ST_SPARE_HI:ST_SPARE_LO] == SPARE_ZERO
	) else $error("unassigned status bits not zero");

endmodule // dfs_status_top
